// >>> rtl/ssu_string_unit.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ssu_string_unit (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic [2:0] op_kind_in,
	input wire logic [23:0] ext_in,
	input wire logic search_back_in,
	input wire logic [3:0] cond_in,
	input wire logic [31:0] count_in,
	input wire logic [31:0] src_in,
	input wire logic [31:0] dst_in,
	input wire logic [31:0] insn_pc_in,
	input wire logic irq_in,
	input wire logic user_mode_in,
	input wire logic [6:0] cr_code_in,
	input wire logic [31:0] cr_value_in,
	input wire logic cr_known_in,
	input wire logic multi_predec_in,
	input wire logic [1:0] multi_bank_in,
	input wire logic mem_ready_in,
	input wire logic [15:0] mem_rdata_in,
	output logic busy_out,
	output logic done_out,
	output logic intr_out,
	output logic illegal_out,
	output logic priv_out,
	output logic mem_read_out,
	output logic mem_write_out,
	output logic mem_word_out,
	output logic [31:0] mem_addr_out,
	output logic [31:0] mem_wdata_out,
	output logic [15:0] count_out,
	output logic [31:0] dst_out,
	output logic [15:0] result_out,
	output logic result_we_out,
	output logic zero_flag_out,
	output logic flags_we_out,
	output logic [31:0] stacked_pc_out,
	output logic flush_out,
	output logic irq_block_out,
	output logic cr_long_out,
	output logic multi_down_out,
	output logic [1:0] multi_bank_out
);
	typedef enum logic [2:0] {SSU_IDLE, SSU_ACCESS, SSU_DONE, SSU_INTR, SSU_FAULT} ssu_state_t;
	ssu_state_t state;
	ssu_state_t next_state;
	logic [2:0] kind;
	logic word;
	logic back;
	logic [15:0] count;
	logic [15:0] init_count;
	logic [31:0] dst;
	logic [15:0] src_op;
	logic [3:0] cond;
	logic zflag;
	logic [31:0] pc_hold;
	logic set_done;
	logic [15:0] result;
	logic res_we;
	logic flg_we;

	wire dec_word;
	wire dec_back;
	wire dec_illegal;
	ssu_decode u_decode (
		.op_kind_in(op_kind_in),
		.ext_in(ext_in),
		.size_word_out(dec_word),
		.dir_back_out(dec_back),
		.illegal_out(dec_illegal),
		.sel_count_out(),
		.sel_src_out(),
		.sel_dst_out()
	);

	wire c_n;
	wire c_z;
	wire c_v;
	wire c_c;
	ssu_cond u_cond (
		.size_word_in(word),
		.dst_data_in(mem_rdata_in),
		.src_data_in(src_op),
		.neg_out(c_n),
		.zero_out(c_z),
		.ovf_out(c_v),
		.carry_out(c_c)
	);

	// Full 16-entry condition table, evaluated here on the compare flags from ssu_cond
	function automatic logic cond_true(input logic [3:0] sel, input logic n, input logic z,
		input logic v, input logic c);
		case (sel)
			4'h0: cond_true = 1'b1;
			4'h1: cond_true = 1'b0;
			4'h2: cond_true = !c && !z;
			4'h3: cond_true = c || z;
			4'h4: cond_true = !c;
			4'h5: cond_true = c;
			4'h6: cond_true = !z;
			4'h7: cond_true = z;
			4'h8: cond_true = !v;
			4'h9: cond_true = v;
			4'hA: cond_true = !n;
			4'hB: cond_true = n;
			4'hC: cond_true = (n == v);
			4'hD: cond_true = (n != v);
			4'hE: cond_true = (n == v) && !z;
			default: cond_true = (n != v) || z;
		endcase
	endfunction

	function automatic logic [31:0] step_of(input logic w);
		step_of = w ? ssu_pkg::STEP_WORD : ssu_pkg::STEP_BYTE;
	endfunction

	wire is_string = (op_kind_in == ssu_pkg::OP_MOVE) || (op_kind_in == ssu_pkg::OP_SEARCH)
		|| (op_kind_in == ssu_pkg::OP_STORE);
	wire is_search = (kind == ssu_pkg::OP_SEARCH);
	wire [15:0] start_count = count_in[15:0];
	wire [31:0] step = step_of(word);
	// Backward forms move the pointer before touching memory
	wire [31:0] access_addr = back ? (dst - step) : dst;
	wire [31:0] next_ptr = back ? (dst - step) : (dst + step);
	wire [15:0] count_dec = count - 16'h0001;
	wire hit = is_search && cond_true(cond, c_n, c_z, c_v, c_c);
	wire step_ok = mem_ready_in && (state == SSU_ACCESS);
	wire last_step = (count_dec == ssu_pkg::COUNT_ZERO) || hit;
	wire cr_priv = (cr_code_in == ssu_pkg::CR_BANK_MODE) || (cr_code_in == ssu_pkg::CR_GLOBAL_BANK)
		|| (cr_code_in == ssu_pkg::CR_STATUS) || (cr_code_in == ssu_pkg::CR_EXC_BASE)
		|| (cr_code_in == ssu_pkg::CR_REG_BASE) || (cr_code_in == ssu_pkg::CR_USER_SP)
		|| (cr_code_in == ssu_pkg::CR_INT_BASE);
	wire start_stc = start_in && (state == SSU_IDLE) && (op_kind_in == ssu_pkg::OP_STC);
	wire start_stm = start_in && (state == SSU_IDLE) && (op_kind_in == ssu_pkg::OP_STM);
	wire start_str = start_in && (state == SSU_IDLE) && is_string;

	always_comb begin
		next_state = state;
		case (state)
			SSU_IDLE: begin
				if (start_str) begin
					if (dec_illegal) begin
						next_state = SSU_FAULT;
					end else if (start_count == ssu_pkg::COUNT_ZERO) begin
						next_state = SSU_DONE;
					end else begin
						next_state = SSU_ACCESS;
					end
				end
			end
			SSU_ACCESS: begin
				// Interrupt only in a cycle where no element completes; a stalled access is abandoned
				if (irq_in && !step_ok) begin
					next_state = SSU_INTR;
				end else if (step_ok && last_step) begin
					next_state = SSU_DONE;
				end
			end
			SSU_DONE: next_state = SSU_IDLE;
			SSU_INTR: next_state = SSU_IDLE;
			SSU_FAULT: next_state = SSU_IDLE;
			default: next_state = SSU_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= SSU_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			kind <= ssu_pkg::OP_MOVE;
			word <= 1'b0;
			back <= 1'b0;
			cond <= 4'h0;
			src_op <= 16'h0000;
			pc_hold <= ssu_pkg::DATA_ZERO;
			init_count <= ssu_pkg::COUNT_ZERO;
		end else if (start_str) begin
			kind <= op_kind_in;
			word <= dec_word;
			back <= (op_kind_in == ssu_pkg::OP_SEARCH) ? search_back_in : dec_back;
			cond <= cond_in;
			src_op <= dec_word ? src_in[15:0] : {8'h00, src_in[7:0]};
			pc_hold <= insn_pc_in;
			init_count <= start_count;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count <= ssu_pkg::COUNT_ZERO;
			dst <= ssu_pkg::DATA_ZERO;
		end else if (start_str) begin
			count <= start_count;
			dst <= dst_in;
		end else if (step_ok) begin
			count <= count_dec;
			dst <= next_ptr;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			zflag <= 1'b0;
			result <= ssu_pkg::COUNT_ZERO;
			res_we <= 1'b0;
			flg_we <= 1'b0;
			set_done <= 1'b0;
		end else begin
			res_we <= 1'b0;
			flg_we <= 1'b0;
			set_done <= 1'b0;
			if (step_ok && last_step) begin
				set_done <= 1'b1;
				if (is_search) begin
					result <= count_dec;
					res_we <= 1'b1;
					zflag <= !hit;
					flg_we <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flush_out <= 1'b0;
			irq_block_out <= 1'b0;
			cr_long_out <= 1'b0;
			mem_wdata_out <= ssu_pkg::DATA_ZERO;
			multi_down_out <= 1'b0;
			multi_bank_out <= 2'h0;
			priv_out <= 1'b0;
		end else begin
			flush_out <= start_stc && !(cr_priv && user_mode_in);
			irq_block_out <= start_stc;
			priv_out <= start_stc && cr_priv && user_mode_in;
			if (start_stc) begin
				cr_long_out <= (cr_code_in[ssu_pkg::CR_SIZE_MSB:ssu_pkg::CR_SIZE_LSB]
					== ssu_pkg::CR_SIZE_LONG);
				mem_wdata_out <= cr_known_in ? cr_value_in : ssu_pkg::DATA_ZERO;
			end else if (start_str) begin
				mem_wdata_out <= {16'h0000, dec_word ? src_in[15:0] : {8'h00, src_in[7:0]}};
			end
			if (start_stm) begin
				multi_down_out <= multi_predec_in;
				multi_bank_out <= multi_bank_in;
			end
		end
	end

	assign busy_out = (state == SSU_ACCESS);
	assign done_out = (state == SSU_DONE);
	assign intr_out = (state == SSU_INTR);
	assign illegal_out = (state == SSU_FAULT);
	// Search reads, store writes, move reads destination side too (data path outside)
	assign mem_read_out = busy_out && (kind != ssu_pkg::OP_STORE);
	assign mem_write_out = busy_out && (kind == ssu_pkg::OP_STORE);
	assign mem_word_out = word;
	assign mem_addr_out = access_addr;
	assign count_out = count;
	assign dst_out = dst;
	assign result_out = result;
	assign result_we_out = res_we;
	assign zero_flag_out = zflag;
	assign flags_we_out = flg_we;
	assign stacked_pc_out = pc_hold;

	a_zero_count_idle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		start_str && !dec_illegal && start_count == 16'h0000 |=> done_out && !busy_out && !flags_we_out && !result_we_out)
		else $error("zero count not idle");
	a_bad_size_fault: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		start_str && dec_illegal |=> illegal_out && !busy_out)
		else $error("no illegal trap");
	a_count_decrements: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		step_ok |=> count_out == $past(count) - 16'h0001)
		else $error("count step wrong");
	a_fwd_ptr_step: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		step_ok && !back |=> dst_out == $past(dst) + $past(step))
		else $error("fwd ptr");
	a_bwd_addr_first: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		busy_out && back |-> mem_addr_out == dst - step)
		else $error("bwd addr");
	a_result_write: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		step_ok && last_step && is_search
		|=> result_we_out && result_out == $past(count_dec) ##1 !result_we_out)
		else $error("result");
	a_zero_flag_miss: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		step_ok && is_search && !hit && count_dec == 16'h0000 |=> zero_flag_out)
		else $error("zero flag");
	a_zero_flag_hit: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		step_ok && hit |=> !zero_flag_out && flags_we_out)
		else $error("zero flag on hit");
	a_irq_stops: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		busy_out && irq_in && !mem_ready_in
		|=> intr_out && stacked_pc_out == $past(pc_hold) ##1 !busy_out)
		else $error("irq");
	a_intr_resume: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		intr_out |-> count_out != 16'h0000 && count_out <= init_count)
		else $error("interrupt count");
	a_done_after_last: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		set_done |-> done_out && (is_search || count_out == 16'h0000))
		else $error("done after last element");
	a_stc_no_irq: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		start_stc |=> irq_block_out)
		else $error("stc irq block");
	a_store_writes: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		busy_out && kind == ssu_pkg::OP_STORE |-> mem_write_out && !mem_read_out && mem_wdata_out[15:0] == src_op)
		else $error("store no write");

	c_search_hit: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
		step_ok && hit && count_dec != 16'h0000);
	c_store_done: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
		done_out && kind == ssu_pkg::OP_STORE);
	c_interrupted: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) intr_out);
	c_priv_stc: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) priv_out);
endmodule
`default_nettype wire

// >>> rtl/ssu_pkg.sv
package ssu_pkg;
	// Size field codes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	// Direction field codes
	localparam logic [2:0] DIR_MOVE_FWD = 3'h2;
	localparam logic [2:0] DIR_MOVE_BWD = 3'h5;
	localparam logic [2:0] DIR_STORE_FWD = 3'h0;
	localparam logic [2:0] DIR_STORE_BWD = 3'h4;
	localparam logic [2:0] DIR_SEARCH = 3'h0;
	// Store extension word layout
	localparam logic [5:0] STORE_OPCODE = 6'h25;
	localparam int EXT_OPC_MSB = 23;
	localparam int EXT_OPC_LSB = 18;
	localparam int EXT_SZ_MSB = 17;
	localparam int EXT_SZ_LSB = 16;
	localparam int EXT_ZERO_BIT = 15;
	localparam int EXT_DIR_MSB = 14;
	localparam int EXT_DIR_LSB = 12;
	localparam int EXT_RC_LSB = 8;
	localparam int EXT_RS_LSB = 4;
	localparam int EXT_RD_LSB = 0;
	// Instruction kinds
	localparam logic [2:0] OP_MOVE = 3'h0;
	localparam logic [2:0] OP_SEARCH = 3'h1;
	localparam logic [2:0] OP_STORE = 3'h2;
	localparam logic [2:0] OP_STC = 3'h3;
	localparam logic [2:0] OP_STM = 3'h4;
	// Control register codes
	localparam logic [6:0] CR_BANK_MODE = 7'h01;
	localparam logic [6:0] CR_GLOBAL_BANK = 7'h02;
	localparam logic [6:0] CR_STATUS = 7'h03;
	localparam logic [6:0] CR_EXC_BASE = 7'h04;
	localparam logic [6:0] CR_REG_BASE = 7'h05;
	localparam logic [6:0] CR_USER_SP = 7'h06;
	localparam logic [6:0] CR_INT_BASE = 7'h07;
	localparam int CR_SIZE_MSB = 6;
	localparam int CR_SIZE_LSB = 5;
	localparam logic [1:0] CR_SIZE_LONG = 2'h3;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG = 32'h0000_0004;
endpackage

// >>> rtl/ssu_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Field decode of one extension word
module ssu_decode (
	input wire logic [2:0] op_kind_in,
	input wire logic [23:0] ext_in,
	output logic size_word_out,
	output logic dir_back_out,
	output logic illegal_out,
	output logic [3:0] sel_count_out,
	output logic [3:0] sel_src_out,
	output logic [3:0] sel_dst_out
);
	wire [1:0] sz_field = ext_in[ssu_pkg::EXT_SZ_MSB:ssu_pkg::EXT_SZ_LSB];
	wire [2:0] dir_field = ext_in[ssu_pkg::EXT_DIR_MSB:ssu_pkg::EXT_DIR_LSB];
	wire sz_ok = (sz_field == ssu_pkg::SZ_BYTE) || (sz_field == ssu_pkg::SZ_WORD);
	wire store_ok = (ext_in[ssu_pkg::EXT_OPC_MSB:ssu_pkg::EXT_OPC_LSB] == ssu_pkg::STORE_OPCODE)
		&& !ext_in[ssu_pkg::EXT_ZERO_BIT]
		&& ((dir_field == ssu_pkg::DIR_STORE_FWD) || (dir_field == ssu_pkg::DIR_STORE_BWD));
	wire move_ok = (dir_field == ssu_pkg::DIR_MOVE_FWD) || (dir_field == ssu_pkg::DIR_MOVE_BWD);
	wire search_ok = (dir_field == ssu_pkg::DIR_SEARCH);
	// Search direction is not in the direction field, so it rides on bit 2 only for move/store
	assign size_word_out = (sz_field == ssu_pkg::SZ_WORD);
	assign dir_back_out = (op_kind_in == ssu_pkg::OP_MOVE) ? (dir_field == ssu_pkg::DIR_MOVE_BWD)
		: (dir_field == ssu_pkg::DIR_STORE_BWD);
	assign illegal_out = !sz_ok
		|| ((op_kind_in == ssu_pkg::OP_STORE) && !store_ok)
		|| ((op_kind_in == ssu_pkg::OP_MOVE) && !move_ok)
		|| ((op_kind_in == ssu_pkg::OP_SEARCH) && !search_ok);
	assign sel_count_out = ext_in[ssu_pkg::EXT_RC_LSB +: 4];
	assign sel_src_out = ext_in[ssu_pkg::EXT_RS_LSB +: 4];
	assign sel_dst_out = ext_in[ssu_pkg::EXT_RD_LSB +: 4];
endmodule
`default_nettype wire

// >>> rtl/ssu_cond.sv
`timescale 1ns/10ps
`default_nettype none
// Compare step: destination minus source, flags from the difference
module ssu_cond (
	input wire logic size_word_in,
	input wire logic [15:0] dst_data_in,
	input wire logic [15:0] src_data_in,
	output logic neg_out,
	output logic zero_out,
	output logic ovf_out,
	output logic carry_out
);
	logic [16:0] diff;
	logic sa;
	logic sb;
	logic sr;
	always_comb begin
		diff = {1'b0, dst_data_in} - {1'b0, src_data_in};
		if (!size_word_in) begin
			diff = {8'h00, {1'b0, dst_data_in[7:0]} - {1'b0, src_data_in[7:0]}};
		end
	end
	assign sa = size_word_in ? dst_data_in[15] : dst_data_in[7];
	assign sb = size_word_in ? src_data_in[15] : src_data_in[7];
	assign sr = size_word_in ? diff[15] : diff[7];
	assign neg_out = sr;
	assign zero_out = size_word_in ? (diff[15:0] == 16'h0000) : (diff[7:0] == 8'h00);
	assign ovf_out = (sa != sb) && (sr != sa);
	assign carry_out = size_word_in ? diff[16] : diff[8];
endmodule
`default_nettype wire

// >>> sim/ssu_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Element memory behind the string unit; slow mode stalls every other cycle
module ssu_mem_model (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] addr_in,
	input wire logic slow_in,
	output logic ready_out,
	output logic [15:0] rdata_out
);
	logic phase;
	logic [15:0] last_data;
	wire logic access = read_in | write_in;
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase <= 1'b0;
			last_data <= 16'h0000;
		end else begin
			phase <= access ? ~phase : 1'b0;
			if (read_in && ready_out)
				last_data <= rdata_out;
		end
	end
	assign ready_out = access & (~slow_in | phase);
	// Outside a completed read the data bus never holds a stale value
	assign rdata_out = (read_in && ready_out) ? (addr_in[15:0] ^ 16'h5A5A) : ~last_data;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic ref_clk_in = 1'b0, rstn_in = 1'b0, start_in = 1'b0, search_back_in = 1'b0;
	logic irq_in = 1'b0, user_mode_in = 1'b0, cr_known_in = 1'b0, multi_predec_in = 1'b0;
	logic slow = 1'b0;
	logic [2:0] op_kind_in = 3'h0;
	logic [23:0] ext_in = 24'h000000;
	logic [3:0] cond_in = 4'h0;
	logic [31:0] count_in = 32'h0, src_in = 32'h0, dst_in = 32'h0, insn_pc_in = 32'h0;
	logic [31:0] cr_value_in = 32'h0;
	logic [6:0] cr_code_in = 7'h00;
	logic [1:0] multi_bank_in = 2'h0;
	wire logic mem_ready_in;
	wire logic [15:0] mem_rdata_in;
	logic busy_out, done_out, intr_out, illegal_out, priv_out, mem_read_out, mem_write_out;
	logic mem_word_out, result_we_out, zero_flag_out, flags_we_out, flush_out;
	logic irq_block_out, cr_long_out, multi_down_out;
	logic [31:0] mem_addr_out, mem_wdata_out, dst_out, stacked_pc_out;
	logic [15:0] count_out, result_out;
	logic [1:0] multi_bank_out;
	int miscompares = 0, compares = 0, n_acc = 0, irq_at = 1000;
	logic [31:0] exp_addr, delta;
	logic [15:0] exp_wdata, wmask;
	logic e_done, e_intr, e_ill, e_rwe, e_fwe, acc_p, acc_f, acc_b, raise;

	ssu_string_unit dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .start_in(start_in),
		.op_kind_in(op_kind_in), .ext_in(ext_in), .search_back_in(search_back_in),
		.cond_in(cond_in), .count_in(count_in), .src_in(src_in), .dst_in(dst_in),
		.insn_pc_in(insn_pc_in), .irq_in(irq_in), .user_mode_in(user_mode_in),
		.cr_code_in(cr_code_in), .cr_value_in(cr_value_in), .cr_known_in(cr_known_in),
		.multi_predec_in(multi_predec_in), .multi_bank_in(multi_bank_in),
		.mem_ready_in(mem_ready_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
		.done_out(done_out), .intr_out(intr_out), .illegal_out(illegal_out),
		.priv_out(priv_out), .mem_read_out(mem_read_out), .mem_write_out(mem_write_out),
		.mem_word_out(mem_word_out), .mem_addr_out(mem_addr_out),
		.mem_wdata_out(mem_wdata_out), .count_out(count_out), .dst_out(dst_out),
		.result_out(result_out), .result_we_out(result_we_out),
		.zero_flag_out(zero_flag_out), .flags_we_out(flags_we_out),
		.stacked_pc_out(stacked_pc_out), .flush_out(flush_out),
		.irq_block_out(irq_block_out), .cr_long_out(cr_long_out),
		.multi_down_out(multi_down_out), .multi_bank_out(multi_bank_out));

	ssu_mem_model mem_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .read_in(mem_read_out),
		.write_in(mem_write_out), .addr_in(mem_addr_out), .slow_in(slow),
		.ready_out(mem_ready_in), .rdata_out(mem_rdata_in));

	always #4 ref_clk_in = ~ref_clk_in;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [23:0] ext(input logic [1:0] sz, input logic [2:0] dir);
		// Distinct count, source and destination selectors
		return {ssu_pkg::STORE_OPCODE, sz, 1'b0, dir, 4'h1, 4'h2, 4'h3};
	endfunction

	task automatic setup(input logic [31:0] first, input logic [31:0] stp, input logic [15:0] m);
		exp_addr = first;
		delta = stp;
		wmask = m;
		n_acc = 0;
	endtask

	// Every completed element is checked against the expected walk
	always @(posedge ref_clk_in) begin
		if (rstn_in && (mem_write_out | mem_read_out) === 1'b1 && mem_ready_in === 1'b1) begin
			chk(mem_addr_out, exp_addr);
			chk({31'h0, busy_out}, 32'h1);
			if (mem_write_out === 1'b1)
				chk({16'h0000, mem_wdata_out[15:0] & wmask}, {16'h0000, exp_wdata & wmask});
			exp_addr = exp_addr + delta;
			n_acc++;
		end
	end

	task automatic run(input logic [2:0] op, input logic [23:0] e, input logic [31:0] cnt,
			input logic [31:0] dst);
		int i;
		@(posedge ref_clk_in);
		op_kind_in <= op;
		ext_in <= e;
		count_in <= cnt;
		dst_in <= dst;
		irq_in <= 1'b0;
		start_in <= 1'b1;
		@(posedge ref_clk_in);
		start_in <= 1'b0;
		for (i = 0; i < 300; i++) begin
			#1;
			if ((done_out | intr_out | illegal_out) === 1'b1)
				break;
			raise = (n_acc >= irq_at);
			@(posedge ref_clk_in);
			irq_in <= raise;
		end
		if (i == 300) begin
			miscompares++;
			test_done();
		end
		e_done = done_out;
		e_intr = intr_out;
		e_ill = illegal_out;
		e_rwe = result_we_out;
		e_fwe = flags_we_out;
	endtask

	task automatic issue(input logic [2:0] op);
		@(posedge ref_clk_in);
		op_kind_in <= op;
		start_in <= 1'b1;
		acc_p = 1'b0;
		acc_f = 1'b0;
		acc_b = 1'b0;
		@(posedge ref_clk_in);
		start_in <= 1'b0;
		repeat (3) begin
			#1;
			acc_p = acc_p | priv_out;
			acc_f = acc_f | flush_out;
			acc_b = acc_b | irq_block_out;
			@(posedge ref_clk_in);
		end
	endtask

	initial begin
		logic [31:0] rem;
		logic [31:0] mid;
		repeat (4) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		src_in <= 32'h1234_56C3;
		insn_pc_in <= 32'h0000_0400;
		cr_value_in <= 32'h8765_4321;
		exp_wdata = 16'h56C3;
		// Store forward bytes; upper count half must be ignored
		setup(32'h0000_1000, ssu_pkg::STEP_BYTE, 16'h00FF);
		run(ssu_pkg::OP_STORE, ext(ssu_pkg::SZ_BYTE, ssu_pkg::DIR_STORE_FWD),
			32'hABCD_0003, 32'h0000_1000);
		chk({31'h0, e_done}, 32'h1);
		chk(n_acc, 32'h3);
		chk(dst_out, 32'h0000_1003);
		chk({31'h0, mem_word_out}, 32'h0);
		// Store backward words against a stalling memory
		slow <= 1'b1;
		setup(32'h0000_1FFE, 32'hFFFF_FFFE, 16'hFFFF);
		run(ssu_pkg::OP_STORE, ext(ssu_pkg::SZ_WORD, ssu_pkg::DIR_STORE_BWD),
			32'h0000_0002, 32'h0000_2000);
		chk(n_acc, 32'h2);
		chk(dst_out, 32'h0000_1FFC);
		chk({31'h0, mem_word_out}, 32'h1);
		// Bad sizes and zero count never touch memory
		for (int s = 2; s < 4; s++) begin
			setup(32'h0, 32'h0, 16'h0);
			run(ssu_pkg::OP_STORE, ext(s[1:0], ssu_pkg::DIR_STORE_FWD),
				32'h0000_0003, 32'h0000_1000);
			chk({31'h0, e_ill}, 32'h1);
			chk(n_acc, 32'h0);
		end
		run(ssu_pkg::OP_STORE, ext(ssu_pkg::SZ_BYTE, ssu_pkg::DIR_STORE_FWD),
			32'h0000_0000, 32'h0000_1000);
		chk({31'h0, e_done}, 32'h1);
		chk(n_acc, 32'h0);
		// Interrupt in mid-store, then resume from the reported state
		setup(32'h0000_3000, ssu_pkg::STEP_BYTE, 16'h00FF);
		irq_at = 1;
		run(ssu_pkg::OP_STORE, ext(ssu_pkg::SZ_BYTE, ssu_pkg::DIR_STORE_FWD),
			32'h0000_0004, 32'h0000_3000);
		irq_at = 1000;
		rem = 32'h4 - n_acc;
		mid = dst_out;
		chk({31'h0, e_intr}, 32'h1);
		// The element completing beside the request finishes first
		chk(n_acc, 32'h2);
		chk({16'h0000, count_out}, rem);
		chk(mid, 32'h0000_3000 + n_acc);
		chk(stacked_pc_out, 32'h0000_0400);
		setup(mid, ssu_pkg::STEP_BYTE, 16'h00FF);
		run(ssu_pkg::OP_STORE, ext(ssu_pkg::SZ_BYTE, ssu_pkg::DIR_STORE_FWD),
			rem, mid);
		chk(dst_out, 32'h0000_3004);
		// Condition 0 holds at once: one compare each way
		slow <= 1'b0;
		for (int b = 0; b < 2; b++) begin
			search_back_in <= b[0];
			setup(b ? 32'h0000_4FFE : 32'h0000_4000, 32'h0, 16'h0);
			run(ssu_pkg::OP_SEARCH, ext(b ? ssu_pkg::SZ_WORD : ssu_pkg::SZ_BYTE, ssu_pkg::DIR_SEARCH),
				32'h0000_0005, b ? 32'h0000_5000 : 32'h0000_4000);
			chk(n_acc, 32'h1);
			chk({29'h0, e_rwe, e_fwe, zero_flag_out}, 32'h6);
			chk({16'h0000, result_out}, 32'h0000_0004);
			chk(dst_out, b ? 32'h0000_4FFE : 32'h0000_4001);
		end
		// Never-true condition runs out; equal condition hits the third byte
		search_back_in <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			cond_in <= k ? 4'h7 : 4'h1;
			setup(k ? 32'h0000_4097 : 32'h0000_4000, ssu_pkg::STEP_BYTE, 16'h0000);
			run(ssu_pkg::OP_SEARCH, ext(ssu_pkg::SZ_BYTE, ssu_pkg::DIR_SEARCH),
				k ? 32'h0000_0005 : 32'h0000_0003, k ? 32'h0000_4097 : 32'h0000_4000);
			chk(n_acc, 32'h3);
			chk({16'h0000, result_out}, k ? 32'h0000_0002 : 32'h0000_0000);
			chk({31'h0, zero_flag_out}, k ? 32'h0 : 32'h1);
			chk(dst_out, k ? 32'h0000_409A : 32'h0000_4003);
		end
		// Zero search count keeps result, flags and memory untouched
		setup(32'h0, 32'h0, 16'h0);
		run(ssu_pkg::OP_SEARCH, ext(ssu_pkg::SZ_BYTE, ssu_pkg::DIR_SEARCH),
			32'hFFFF_0000, 32'h0000_4000);
		chk({29'h0, e_rwe, e_fwe, zero_flag_out}, 32'h0);
		chk({16'h0000, result_out}, 32'h0000_0002);
		chk(n_acc, 32'h0);
		// Control register store: privilege, flush, interrupt block, size, value
		user_mode_in <= 1'b1;
		for (int c = 1; c < 10; c++) begin
			cr_code_in <= (c == 8) ? 7'h60 : ((c == 9) ? 7'h08 : c[6:0]);
			cr_known_in <= (c < 8);
			issue(ssu_pkg::OP_STC);
			// A refused privileged store does not flush the queue
			chk({29'h0, acc_p, acc_f, acc_b}, (c < 8) ? 32'h5 : 32'h3);
			chk({31'h0, cr_long_out}, (c == 8) ? 32'h1 : 32'h0);
			chk(mem_wdata_out, (c < 8) ? 32'h8765_4321 : 32'h0000_0000);
		end
		user_mode_in <= 1'b0;
		cr_code_in <= ssu_pkg::CR_STATUS;
		issue(ssu_pkg::OP_STC);
		chk({29'h0, acc_p, acc_f, acc_b}, 32'h3);
		// Multi-register store order and bank pass through
		for (int m = 0; m < 2; m++) begin
			multi_predec_in <= m[0];
			multi_bank_in <= m ? 2'h2 : 2'h1;
			issue(ssu_pkg::OP_STM);
			chk({29'h0, multi_down_out, multi_bank_out}, m ? 32'h6 : 32'h1);
		end
		test_done();
	end
endmodule
`default_nettype wire
